// [dtd_pkg.sv]
package dtd_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_BYTE_CTL    = 3'h0;
    localparam logic [2:0] IDX_SHARED_CTL  = 3'h1;
    localparam logic [2:0] IDX_WORD_CTL    = 3'h2;
    localparam logic [2:0] IDX_EXTRA_CTL   = 3'h3;
    localparam logic [2:0] IDX_BYTE_LOW    = 3'h4;
    localparam logic [2:0] IDX_BYTE_HIGH   = 3'h5;
    localparam logic [2:0] IDX_WORD_LOW    = 3'h6;
    localparam logic [2:0] IDX_WORD_HIGH   = 3'h7;
    localparam int         ADDR_W          = 8;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_EN    = 7;  // Timer control: enable
    localparam int BIT_SPASS = 6;  // Timer control: single-pass
    localparam int BIT_TOUT  = 5;  // Timer control: timeout status
    localparam int BIT_IEN   = 1;  // Timer control: interrupt enable
    localparam int BIT_MODE  = 7;  // Shared: demodulation mode
    localparam int BIT_SEL   = 6;  // Shared: pin select
    localparam int BIT_RISE  = 1;  // Shared: byte init level / rise flag
    localparam int BIT_FALL  = 0;  // Shared: word init level / fall flag

    // ------------------------------------------------------------
    // Reset values and timing counts
    // ------------------------------------------------------------
    localparam logic [7:0]  CTL_RST      = 8'h00;
    localparam logic [15:0] RELOAD_RST   = 16'h0000;
    localparam logic [4:0]  EXTRA_RO     = 5'h1f;
    localparam logic [15:0] BYTE_MASK    = 16'h00ff;
    localparam logic [15:0] WORD_MASK    = 16'hffff;
    localparam logic [3:0]  FILT_NONE    = 4'h1;
    localparam logic [3:0]  FILT_SHORT   = 4'h4;
    localparam logic [3:0]  FILT_LONG    = 4'h8;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SUB_NORMAL = 2'h0, SUB_ALT = 2'h1, SUB_FORCE0 = 2'h2, SUB_FORCE1 = 2'h3
    } dtd_sub_t;
    typedef enum logic [1:0] {
        LOG_AND = 2'h0, LOG_OR = 2'h1, LOG_NOR = 2'h2, LOG_NAND = 2'h3
    } dtd_logic_t;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
endpackage

// [dtd_timer_pair.sv]
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dtd_timer_pair (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rstn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [dtd_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Pins and port latch
    input  wire logic                        demodInputPinA,
    input  wire logic                        demodInputPinB,
    input  wire logic                        portLatchBit,
    output logic                             byteTimerOutput,
    output logic                             wordTimerOutput,
    output logic                             combinedOutputPin,
    // Interrupt requests
    output logic                             interruptLineTwo,
    output logic                             interruptLineThree,
    output logic                             interruptLineFour
);
    import dtd_pkg::*;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [7:0]  ctl_ff [2];
    logic [7:0]  nxt_ctl [2];
    logic [15:0] lowRld_ff [2];
    logic [15:0] highRld_ff [2];
    logic [5:0]  cfg_ff;
    logic [1:0]  initLvl_ff;
    logic        riseFlag_ff;
    logic        fallFlag_ff;
    logic [2:0]  extraHi_ff;
    logic [31:0] prdata_ff;

    // Address decode; zero-wait slave, misaligned or out of range errors
    wire       addrOk  = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:5] == '0);
    wire [2:0] regIdx  = paddr[4:2];
    wire       regWr   = psel && penable && pwrite && addrOk;
    wire       shWr    = regWr && (regIdx == IDX_SHARED_CTL);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addrOk;
    assign prdata  = prdata_ff;

    // Shared configuration fields
    wire       demodMode = cfg_ff[BIT_MODE-2];
    wire       txMode    = !demodMode;
    wire       pinSel    = cfg_ff[BIT_SEL-2];
    wire [1:0] logicSel  = cfg_ff[3:2];
    wire [1:0] subSel    = cfg_ff[1:0];
    wire [1:0] initBit   = {initLvl_ff[BIT_FALL], initLvl_ff[BIT_RISE]};
    wire       altActive = txMode && (subSel == SUB_ALT);
    wire       wordForce = txMode && subSel[1];

    // Read selection; flags replace init levels in demodulation mode
    function automatic logic [7:0] regRead(input logic [2:0] idx);
        logic [1:0] low2;
        low2 = demodMode ? {riseFlag_ff, fallFlag_ff} : initLvl_ff;
        case (idx)
            IDX_BYTE_CTL:   regRead = ctl_ff[0];
            IDX_SHARED_CTL: regRead = {cfg_ff, low2};
            IDX_WORD_CTL:   regRead = ctl_ff[1];
            IDX_EXTRA_CTL:  regRead = {extraHi_ff, EXTRA_RO};
            default:        regRead = 8'h00;
        endcase
    endfunction
    wire [15:0] rdReload = (regIdx == IDX_BYTE_LOW)  ? lowRld_ff[0]  :
                           (regIdx == IDX_BYTE_HIGH) ? highRld_ff[0] :
                           (regIdx == IDX_WORD_LOW)  ? lowRld_ff[1]  : highRld_ff[1];
    wire [31:0] rdMux    = !addrOk ? 32'h0000_0000 :
                           regIdx[2] ? {16'h0000, rdReload} : {24'h00_0000, regRead(regIdx)};

    // Read data captured in the setup cycle, held through the access
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_ff <= rdMux;
        end
    end

    // Shared and extra configuration; init levels only written in transmit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_ff     <= CTL_RST[7:2];
            initLvl_ff <= CTL_RST[1:0];
            extraHi_ff <= CTL_RST[7:5];
        end else begin
            if (shWr) begin
                cfg_ff <= pwdata[7:2];
            end
            if (shWr && txMode) begin
                initLvl_ff <= pwdata[1:0];
            end
            if (regWr && regIdx == IDX_EXTRA_CTL) begin
                extraHi_ff <= pwdata[7:5];
            end
        end
    end

    // ------------------------------------------------------------
    // Demodulation input path
    // ------------------------------------------------------------
    logic [1:0] pinMeta_ff;
    logic [1:0] pinSync_ff;
    logic [3:0] filtCnt_ff;
    logic       filtLvl_ff;
    logic       filtPrev_ff;
    logic       irqTwo_ff;

    // Both pins synchronised before the select, so the mux never sees a raw pin
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinMeta_ff <= 2'h0;
            pinSync_ff <= 2'h0;
        end else begin
            pinMeta_ff <= {demodInputPinB, demodInputPinA};
            pinSync_ff <= pinMeta_ff;
        end
    end

    wire       syncSel  = pinSync_ff[pinSel];
    wire [3:0] filtNeed = (subSel == 2'h1) ? FILT_SHORT :
                          (subSel == 2'h2) ? FILT_LONG : FILT_NONE;
    wire       filtDiff = (syncSel != filtLvl_ff);
    wire       filtTake = filtDiff && (filtCnt_ff == filtNeed - 4'h1);

    // A new level must persist filtNeed cycles; shorter pulses reset the count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            filtCnt_ff  <= 4'h0;
            filtLvl_ff  <= 1'b0;
            filtPrev_ff <= 1'b0;
        end else begin
            filtCnt_ff  <= (filtDiff && !filtTake) ? filtCnt_ff + 4'h1 : 4'h0;
            filtLvl_ff  <= filtTake ? syncSel : filtLvl_ff;
            filtPrev_ff <= filtLvl_ff;
        end
    end

    // Polarity choice: 00 falling, 01 rising, 1x both
    wire riseDet = demodMode && filtLvl_ff && !filtPrev_ff && (logicSel != EDGE_FALL);
    wire fallDet = demodMode && !filtLvl_ff && filtPrev_ff && (logicSel != EDGE_RISE);
    wire riseClr = shWr && demodMode && pwdata[BIT_RISE];
    wire fallClr = shWr && demodMode && pwdata[BIT_FALL];

    // Sticky edge flags; a detection in the clearing cycle survives
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            riseFlag_ff <= 1'b0;
            fallFlag_ff <= 1'b0;
            irqTwo_ff   <= 1'b0;
        end else begin
            riseFlag_ff <= (riseFlag_ff && !riseClr) || riseDet;
            fallFlag_ff <= (fallFlag_ff && !fallClr) || fallDet;
            irqTwo_ff   <= pinSel && (riseDet || fallDet);
        end
    end
    assign interruptLineTwo = irqTwo_ff;

    // ------------------------------------------------------------
    // Timers: index 0 byte timer, index 1 word timer
    // ------------------------------------------------------------
    logic [15:0] cnt_ff [2];
    logic [1:0]  outLvl_ff;
    logic [1:0]  enPrev_ff;
    logic [1:0]  irqTmr_ff;
    logic [1:0]  startEv;
    logic [1:0]  termEv;
    logic [1:0]  toutSet;
    logic [1:0]  altKick;

    for (genvar i = 0; i < 2; i++) begin : g_tmr
        localparam logic [15:0] MASK   = (i == 0) ? BYTE_MASK : WORD_MASK;
        localparam logic [2:0]  CTLIDX = (i == 0) ? IDX_BYTE_CTL : IDX_WORD_CTL;
        localparam logic [2:0]  LOWIDX = (i == 0) ? IDX_BYTE_LOW : IDX_WORD_LOW;
        localparam logic [2:0]  HIIDX  = (i == 0) ? IDX_BYTE_HIGH : IDX_WORD_HIGH;
        wire en     = ctl_ff[i][BIT_EN];
        wire spass  = ctl_ff[i][BIT_SPASS];
        wire newLvl = !outLvl_ff[i];
        wire forced = (i == 1) && wordForce;

        // Enable edge starts a pass; a count of one ends on the next edge
        assign startEv[i] = en && !enPrev_ff[i];
        assign termEv[i]  = en && !startEv[i] && (cnt_ff[i] == 16'h0001);
        assign toutSet[i] = termEv[i] && (spass || (newLvl == initBit[i]));
        assign altKick[i] = altActive && termEv[1-i] && ctl_ff[1-i][BIT_SPASS];

        // Software write, then hardware halt, hand-over and status on top
        always_comb begin
            nxt_ctl[i] = ctl_ff[i];
            if (regWr && regIdx == CTLIDX) begin
                nxt_ctl[i]           = pwdata[7:0];
                nxt_ctl[i][BIT_TOUT] = ctl_ff[i][BIT_TOUT] && !pwdata[BIT_TOUT];
            end
            if (termEv[i] && spass) begin
                nxt_ctl[i][BIT_EN] = 1'b0;
            end
            if (altKick[i]) begin
                nxt_ctl[i][BIT_EN] = 1'b1;
            end
            if (toutSet[i]) begin
                nxt_ctl[i][BIT_TOUT] = 1'b1;
            end
        end

        // Loads pick the reload by level; zero wraps to the top of the range
        wire [15:0] nxt_cnt = startEv[i] ? (initBit[i] ? highRld_ff[i] : lowRld_ff[i]) :
                              (termEv[i] && !spass) ? (newLvl ? highRld_ff[i] : lowRld_ff[i]) :
                              en ? ((cnt_ff[i] - 16'h0001) & MASK) : cnt_ff[i];
        wire        nxt_out = forced ? subSel[0] :
                              !en ? !initBit[i] :
                              startEv[i] ? initBit[i] :
                              termEv[i] ? newLvl : outLvl_ff[i];

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                ctl_ff[i]     <= CTL_RST;
                cnt_ff[i]     <= RELOAD_RST;
                outLvl_ff[i]  <= 1'b1;
                enPrev_ff[i]  <= 1'b0;
                irqTmr_ff[i]  <= 1'b0;
            end else begin
                ctl_ff[i]     <= nxt_ctl[i];
                cnt_ff[i]     <= nxt_cnt;
                outLvl_ff[i]  <= nxt_out;
                enPrev_ff[i]  <= en;
                irqTmr_ff[i]  <= toutSet[i] && ctl_ff[i][BIT_IEN];
            end
        end

        // Reload registers; a write in a load cycle gives the old value
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                lowRld_ff[i]  <= RELOAD_RST;
                highRld_ff[i] <= RELOAD_RST;
            end else begin
                if (regWr && regIdx == LOWIDX) begin
                    lowRld_ff[i] <= pwdata[15:0] & MASK;
                end
                if (regWr && regIdx == HIIDX) begin
                    highRld_ff[i] <= pwdata[15:0] & MASK;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic combOut_ff;
    wire  andLvl  = outLvl_ff[0] && outLvl_ff[1];
    wire  orLvl   = outLvl_ff[0] || outLvl_ff[1];
    wire  combFn  = (logicSel == LOG_AND) ? andLvl : (logicSel == LOG_OR) ? orLvl :
                    (logicSel == LOG_NOR) ? !orLvl : !andLvl;

    // Combined pin follows the port latch unless selected in transmit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            combOut_ff <= 1'b0;
        end else begin
            combOut_ff <= (txMode && pinSel) ? combFn : portLatchBit;
        end
    end
    assign combinedOutputPin  = combOut_ff;
    assign byteTimerOutput    = outLvl_ff[0];
    assign wordTimerOutput    = outLvl_ff[1];
    assign interruptLineFour  = irqTmr_ff[0];
    assign interruptLineThree = irqTmr_ff[1];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_idle_level: assert property (!ctl_ff[0][BIT_EN] |=>
        outLvl_ff[0] == !$past(initBit[0])) else $error("idle byte output wrong");
    a_start_load: assert property (startEv[0] |=> outLvl_ff[0] == $past(initBit[0]) &&
        cnt_ff[0] == ($past(initBit[0]) ? $past(highRld_ff[0]) : $past(lowRld_ff[0])))
        else $error("byte start load wrong");
    a_force_low: assert property (wordForce && subSel == SUB_FORCE0 |=> !outLvl_ff[1])
        else $error("word output not forced low");
    a_spass_halt: assert property (termEv[0] && ctl_ff[0][BIT_SPASS] && !altKick[0] |=>
        !ctl_ff[0][BIT_EN] && ctl_ff[0][BIT_TOUT] && outLvl_ff[0] != $past(outLvl_ff[0]))
        else $error("single pass end wrong");
    a_half_quiet: assert property (termEv[0] && !ctl_ff[0][BIT_SPASS] &&
        (!outLvl_ff[0] != initBit[0]) |=> !irqTmr_ff[0]) else $error("half period raised interrupt");
    a_rise_sticky: assert property (riseDet |=> riseFlag_ff ##1 (riseFlag_ff || $past(riseClr)))
        else $error("rise flag lost");
    a_fall_clear: assert property (fallClr && !fallDet |=> !fallFlag_ff)
        else $error("fall flag not cleared");
    a_filter_four: assert property (demodMode && subSel == 2'h1 && $changed(filtLvl_ff) |->
        $past(syncSel, 1) == filtLvl_ff && $past(syncSel, 2) == filtLvl_ff &&
        $past(syncSel, 3) == filtLvl_ff && $past(syncSel, 4) == filtLvl_ff)
        else $error("glitch passed filter");
    a_ping_pong: assert property (altKick[1] |=> ctl_ff[1][BIT_EN] && startEv[1])
        else $error("alternate hand-over missing");
    a_irq_four: assert property (toutSet[0] && ctl_ff[0][BIT_IEN] |=> interruptLineFour)
        else $error("byte timeout interrupt missing");
    a_word_idle: assert property (!wordForce && !ctl_ff[1][BIT_EN] |=>
        outLvl_ff[1] == !$past(initBit[1])) else $error("idle word output wrong");
    a_line_two_b: assert property ((riseDet || fallDet) && pinSel |=> interruptLineTwo)
        else $error("pin B edge missed line two");
    a_line_two_a: assert property ((riseDet || fallDet) && !pinSel |=> !interruptLineTwo)
        else $error("pin A edge raised line two");

    c_modulo_cycle: cover property (termEv[0] && !ctl_ff[0][BIT_SPASS] ##[1:600] toutSet[0]);
    c_ping_pong:    cover property (altKick[1] ##[1:600] altKick[0]);
    c_rise_line2:   cover property (riseDet && pinSel);
    c_pin_a_rise:   cover property (riseDet && !pinSel);
    c_force_high:   cover property (wordForce && subSel == SUB_FORCE1 ##1 outLvl_ff[1]);
endmodule
`default_nettype wire

// [dtd_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dtd_pin_model (
    // Clock
    input  wire logic clk,
    // Pins toward the block
    output logic      pinA,
    output logic      pinB
);
    // ----------------------------------------
    // Pulse driver
    // ----------------------------------------
    // Pins idle low, like a released input
    initial begin
        pinA = 1'b0;
        pinB = 1'b0;
    end

    // High pulse of w cycles, launched after an edge so it never races the synchroniser
    task automatic pulse(input logic onB, input int w);
        @(posedge clk);
        if (onB) pinB <= 1'b1;
        else pinA <= 1'b1;
        repeat (w) @(posedge clk);
        pinA <= 1'b0;
        pinB <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [tb_dual_timer_transmit_demod.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_dual_timer_transmit_demod;
    import dtd_pkg::*;
    logic clk, rstn, psel, penable, pwrite, portLatchBit;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, pinA, pinB;
    logic byteOut, wordOut, combOut, interrupt_line_two, interrupt_line_three, interrupt_line_four;
    int failCount, checksDone;

    dtd_timer_pair i_dtd_timer_pair (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .demodInputPinA(pinA), .demodInputPinB(pinB),
        .portLatchBit(portLatchBit), .byteTimerOutput(byteOut), .wordTimerOutput(wordOut),
        .combinedOutputPin(combOut), .interruptLineTwo(interrupt_line_two), .interruptLineThree(interrupt_line_three),
        .interruptLineFour(interrupt_line_four));
    dtd_pin_model i_dtd_pin_model (.clk(clk), .pinA(pinA), .pinB(pinB));

    // ----------------------------------------
    // Common tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failCount++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // One APB transfer; holds everything until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        apb(1'b1, {3'h0, idx, 2'h0}, {24'h0, d});
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd[4:0], EXTRA_RO);
        apb(1'b0, 8'h20, 32'h0);
        chk(err, 1'b1);
        settle();
        chk(byteOut, 1'b1);
        wr(IDX_SHARED_CTL, 8'h03);
        settle();
        chk(byteOut, 1'b0);
        chk(wordOut, 1'b0);
    endtask

    // Forced levels win over the disabled inverse level
    task automatic t_force();
        wr(IDX_SHARED_CTL, 8'h08);
        settle();
        chk(wordOut, 1'b0);
        wr(IDX_SHARED_CTL, 8'h0d);
        settle();
        chk(wordOut, 1'b1);
    endtask

    // Both timers idle high: AND, OR give 1, NOR, NAND give 0
    task automatic t_combine();
        for (int k = 0; k < 4; k++) begin
            wr(IDX_SHARED_CTL, 8'(8'h40 | (k << 4)));
            settle();
            chk(combOut, k < 2);
        end
        wr(IDX_SHARED_CTL, 8'h00);
        settle();
        chk(combOut, 1'b1);
        @(posedge clk);
        portLatchBit <= 1'b0;
        settle();
        chk(combOut, 1'b0);
    endtask

    // Single pass from the low reload; pulse expected reload+1 cycles after the write, 257 for a zero reload
    task automatic t_byte(input logic [7:0] rl, input int expN);
        int n;
        n = 0;
        wr(IDX_BYTE_LOW, rl);
        wr(IDX_BYTE_CTL, 8'hc2);
        while (interrupt_line_four !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
            if (n == 2) chk(byteOut, 1'b0);
        end
        chk(n, expN);
        chk(byteOut, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd[7:5], 3'h3);
        wr(IDX_BYTE_CTL, 8'h20);
    endtask

    // Modulo-N: full period is low count plus high count
    task automatic t_modulo();
        int n;
        n = 0;
        wr(IDX_BYTE_HIGH, 8'h03);
        wr(IDX_BYTE_LOW, 8'h02);
        wr(IDX_BYTE_CTL, 8'h82);
        repeat (40) @(posedge clk);
        #1;
        while (interrupt_line_four !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
        end
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (interrupt_line_four !== 1'b1 && n < 40);
        chk(n, 5);
        wr(IDX_BYTE_CTL, 8'h20);
    endtask

    // Byte pass hands over to the word timer
    task automatic t_pingpong();
        int n;
        n = 0;
        wr(IDX_WORD_LOW, 8'h05);
        wr(IDX_BYTE_LOW, 8'h03);
        wr(IDX_WORD_CTL, 8'h42);
        wr(IDX_SHARED_CTL, 8'h04);
        wr(IDX_BYTE_CTL, 8'hc2);
        while (interrupt_line_three !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(interrupt_line_three, 1'b1);
        wr(IDX_SHARED_CTL, 8'h00);
        repeat (4) settle();
        apb(1'b0, 8'h00, 32'h0);
        chk(rd[7], 1'b0);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd[7], 1'b0);
    endtask

    // Pin B, both edges; a glitch under the filter width leaves the flags clear
    task automatic t_demod();
        logic seen2;
        seen2 = 1'b0;
        wr(IDX_SHARED_CTL, 8'he0);
        fork
            i_dtd_pin_model.pulse(1'b1, 6);
            repeat (20) begin
                @(posedge clk);
                #1;
                if (interrupt_line_two === 1'b1) seen2 = 1'b1;
            end
        join
        chk(seen2, 1'b1);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[1:0], 2'h3);
        wr(IDX_SHARED_CTL, 8'he2);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[1:0], 2'h1);
        wr(IDX_SHARED_CTL, 8'he7);
        i_dtd_pin_model.pulse(1'b1, 2);
        settle();
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[1:0], 2'h0);
        i_dtd_pin_model.pulse(1'b1, 6);
        repeat (4) settle();
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[1:0], 2'h3);
        // Pin A, rising edges only: no line two pulse, fall flag stays clear
        seen2 = 1'b0;
        wr(IDX_SHARED_CTL, 8'h93);
        fork
            i_dtd_pin_model.pulse(1'b0, 6);
            repeat (20) begin
                @(posedge clk);
                #1;
                if (interrupt_line_two === 1'b1) seen2 = 1'b1;
            end
        join
        chk(seen2, 1'b0);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[1:0], 2'h2);
    endtask

    // ----------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #40000;
        failCount++;
        close_out();
    end

    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        portLatchBit = 1'b1;
        failCount = 0;
        checksDone = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_force();
        t_combine();
        t_byte(8'h03, 4);
        t_byte(8'h03, 4);
        t_byte(8'h00, 257);
        t_modulo();
        t_pingpong();
        t_demod();
        close_out();
    end
endmodule
`default_nettype wire
